// *** common/wst_pkg.sv ***
// Package of types and constants for the window, state and trap unit
package wst_pkg;

  // ==========================================================
  // Register file geometry
  localparam int unsigned NUM_WIN      = 8;
  localparam int unsigned NUM_GLOBAL   = 8;
  localparam int unsigned GRP_SIZE     = 8;
  localparam int unsigned NUM_REGS     = 136;
  localparam int unsigned WIN_STORE    = 128;

  // ==========================================================
  // State word and trap base field positions
  localparam int unsigned PS_DESIGN_LSB  = 28;
  localparam int unsigned PS_VER_LSB     = 24;
  localparam int unsigned PS_FLAG_N      = 23;
  localparam int unsigned PS_FLAG_Z      = 22;
  localparam int unsigned PS_FLAG_V      = 21;
  localparam int unsigned PS_FLAG_C      = 20;
  localparam int unsigned PS_COPROC_EN   = 13;
  localparam int unsigned PS_FLOAT_EN    = 12;
  localparam int unsigned PS_MASK_LSB    = 8;
  localparam int unsigned PS_PRIV        = 7;
  localparam int unsigned PS_PRIOR_PRIV  = 6;
  localparam int unsigned PS_TRAP_EN     = 5;
  localparam int unsigned TB_TYPE_LSB    = 4;
  localparam int unsigned TB_BASE_LSB    = 12;

  // Arbitrary identification values, not tied to any part
  localparam logic [3:0] DESIGN_ID_VAL = 4'h5;
  localparam logic [3:0] VERSION_VAL   = 4'h1;

  // ==========================================================
  // Reset values
  localparam logic [4:0]  WPTR_RST   = 5'h00;
  localparam logic [7:0]  WIM_RST    = 8'h00;
  localparam logic [19:0] TBASE_RST  = 20'h00000;
  localparam logic [31:0] PPROD_RST  = 32'h00000000;
  localparam logic [3:0]  MASK_RST   = 4'hf;

  // ==========================================================
  // Trap types
  localparam logic [7:0] TT_RESET    = 8'h00;
  localparam logic [7:0] TT_IACC     = 8'h01;
  localparam logic [7:0] TT_ILLEGAL  = 8'h02;
  localparam logic [7:0] TT_PRIV     = 8'h03;
  localparam logic [7:0] TT_FP_DIS   = 8'h04;
  localparam logic [7:0] TT_WOVF     = 8'h05;
  localparam logic [7:0] TT_WUNF     = 8'h06;
  localparam logic [7:0] TT_ALIGN    = 8'h07;
  localparam logic [7:0] TT_FP_EXC   = 8'h08;
  localparam logic [7:0] TT_DACC     = 8'h09;
  localparam logic [7:0] TT_TAG_OVF  = 8'h0a;
  localparam logic [7:0] TT_IRQ_BASE = 8'h10;
  localparam logic [7:0] TT_SW_BASE  = 8'h80;

  // Exception request bit indices; data access ranks below align and float exception
  localparam int unsigned EX_IACC    = 0;
  localparam int unsigned EX_ILLEGAL = 1;
  localparam int unsigned EX_DATA    = 2;
  localparam int unsigned EX_ALIGN   = 3;
  localparam int unsigned EX_FP_EXC  = 4;
  localparam int unsigned EX_TAG_OVF = 5;
  localparam int unsigned EX_WIDTH   = 6;

  // ==========================================================
  // Pipeline operations
  typedef enum logic [3:0] {
    WST_OP_NONE   = 4'h0,
    WST_OP_PUSH   = 4'h1,
    WST_OP_POP    = 4'h2,
    WST_OP_RET    = 4'h3,
    WST_OP_TRAP   = 4'h4,
    WST_OP_RD_PS  = 4'h5,
    WST_OP_WR_PS  = 4'h6,
    WST_OP_RD_WIM = 4'h7,
    WST_OP_WR_WIM = 4'h8,
    WST_OP_RD_TB  = 4'h9,
    WST_OP_WR_TB  = 4'ha,
    WST_OP_RD_PP  = 4'hb,
    WST_OP_WR_PP  = 4'hc,
    WST_OP_FLOAT  = 4'hd
  } wst_op_t;

  typedef struct packed {
    logic        valid;
    wst_op_t     op;
    logic [31:0] wdata;
    logic [6:0]  sw_trap;
    logic        cc_we;
    logic [3:0]  cc_val;
    logic [EX_WIDTH-1:0] exc;
  } wst_req_t;

  typedef struct packed {
    logic        we;
    logic [4:0]  waddr;
    logic [31:0] wdata;
    logic [4:0]  raddr_a;
    logic [4:0]  raddr_b;
  } wst_rf_req_t;

  typedef struct packed {
    logic        taken;
    logic [7:0]  ttype;
    logic [31:0] vector;
  } wst_trap_t;

  typedef enum logic [2:0] {
    WST_ST_RESET = 3'b001,
    WST_ST_RUN   = 3'b010,
    WST_ST_HALT  = 3'b100
  } wst_state_t;

endpackage : wst_pkg

// *** hdl/wst_core.sv ***
// Window, state word and trap control unit top
//
// What this block does
// RL1: 136 working registers of 32 bits; eight globals seen from every window.
// RL2: Eight windows of 24 registers: ins, outs and locals of eight each.
// RL3: Outs of one window are ins of the next, wrapping last to first.
// RL4: Window pointer drops on trap and push, rises on pop and return.
// RL5: State word top nibbles hold fixed design and version codes.
// RL6: Condition flags N Z V C in bits 23 to 20 follow cc-setting ops.
// RL7: Float op traps when float enable is clear or no float unit fitted.
// RL8: Interrupt taken only when its level exceeds the level mask.
// RL9: Privilege bit 1 is supervisor; prior bit keeps it at each trap but reset, which clears it.
// RL10: Trap entry clears trap enable; then irqs ignored, exceptions halt.
// RL11: Software keeps the coprocessor enable bit cleared.
// RL12: Push, pop or return into an invalid window raises over/underflow.
// RL13: Trap base holds 20-bit base, hardware trap type, zero low nibble.
// RL14: Vector is table base plus offset from trap type, 256 entries.
// RL15: Trap taken before the instruction changes visible state.
// RL16: Privileged ops only in supervisor; user enters it only by trap.
// RL17: Exceptions ranked reset first through tag overflow; trap ops 80-ff.
// RL18: Irq levels 15..1 map to types 1f..11 and rank below all else.
// RL19: Partial-product register kept across multiply-step sequence.
// RL20: State word changed by window ops, traps, cc ops and privileged write.
// RL21: Window pointer moves wrap modulo eight.
// RL22: Trap entry copies privilege into prior bit then sets supervisor.
`timescale 1ns/1ps
module wst_core
  import wst_pkg::*;
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rstn,
  input  wire wst_pkg::wst_req_t     i_req,
  input  wire logic                  i_float_present,
  input  wire logic [3:0]            i_irq_level,
  input  wire wst_pkg::wst_rf_req_t  i_rf_req,
  output wst_pkg::wst_trap_t         o_trap,
  output logic [31:0]                o_rdata,
  output logic                       o_halted,
  output logic                       o_supervisor,
  output logic [31:0]                o_rf_a,
  output logic [31:0]                o_rf_b
);
  import wst_pkg::*;

  typedef struct packed {
    wst_state_t  state;
    logic [3:0]  flags;
    logic        coproc_en;
    logic        float_en;
    logic [3:0]  mask;
    logic        priv;
    logic        prior_priv;
    logic        trap_en;
    logic [4:0]  wptr;
    logic [7:0]  window_invalid_mask;
    logic [19:0] tbase;
    logic [7:0]  ttype;
    logic [31:0] pprod;
    wst_trap_t   trap;
    logic [31:0] rdata;
  } wst_regs_t;

  wst_regs_t   r_q;
  wst_regs_t   r_d;
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic        irq_take;
  logic [7:0]  irq_ttype;
  logic [31:0] rf_a;
  logic [31:0] rf_b;
  logic [31:0] ps_word;
  logic [2:0]  w_dec;
  logic [2:0]  w_inc;

  // ==========================================================
  // Reset release
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // Sub blocks
  wst_regfile u_rf (
    .i_core_clk (i_core_clk),
    .i_win      (r_q.wptr[2:0]),
    .i_req      (i_rf_req),
    .o_rdata_a  (rf_a),
    .o_rdata_b  (rf_b)
  );

  wst_irq_pick u_irq (
    .i_level    (i_irq_level),
    .i_mask     (r_q.mask),
    .i_trap_en  (r_q.trap_en),
    .o_take     (irq_take),
    .o_ttype    (irq_ttype)
  );

  // ==========================================================
  // State word image
  always_comb
  begin
    ps_word = 32'h00000000;
    // RL5 Fixed identity nibbles
    ps_word[PS_DESIGN_LSB +: 4] = DESIGN_ID_VAL;
    ps_word[PS_VER_LSB +: 4]    = VERSION_VAL;
    ps_word[PS_FLAG_N]          = r_q.flags[3];
    ps_word[PS_FLAG_Z]          = r_q.flags[2];
    ps_word[PS_FLAG_V]          = r_q.flags[1];
    ps_word[PS_FLAG_C]          = r_q.flags[0];
    ps_word[PS_COPROC_EN]       = r_q.coproc_en;
    ps_word[PS_FLOAT_EN]        = r_q.float_en;
    ps_word[PS_MASK_LSB +: 4]   = r_q.mask;
    ps_word[PS_PRIV]            = r_q.priv;
    ps_word[PS_PRIOR_PRIV]      = r_q.prior_priv;
    ps_word[PS_TRAP_EN]         = r_q.trap_en;
    ps_word[4:0]                = r_q.wptr;
  end

  // RL21 Modulo eight moves
  assign w_dec = r_q.wptr[2:0] - 3'd1;
  assign w_inc = r_q.wptr[2:0] + 3'd1;

  // ==========================================================
  // Next state
  always_comb
  begin
    logic       privop;
    logic       ex_hit;
    logic [7:0] tt;
    logic       take;
    logic       sync_ex;
    r_d          = r_q;
    privop       = 1'b0;
    ex_hit       = 1'b0;
    tt           = TT_RESET;
    take         = 1'b0;
    sync_ex      = 1'b0;
    r_d.trap     = '0;
    r_d.rdata    = 32'h00000000;

    if (i_req.valid)
    begin
      unique case (i_req.op)
        WST_OP_WR_PS, WST_OP_WR_WIM, WST_OP_WR_TB, WST_OP_RET,
        WST_OP_RD_PS, WST_OP_RD_WIM, WST_OP_RD_TB:
          privop = 1'b1;
        default:
          privop = 1'b0;
      endcase
    end

    // RL17 Fixed priority ladder
    if (i_req.valid && i_req.exc[EX_IACC])
    begin
      ex_hit = 1'b1;
      tt     = TT_IACC;
    end
    else if (i_req.valid && i_req.exc[EX_ILLEGAL])
    begin
      ex_hit = 1'b1;
      tt     = TT_ILLEGAL;
    end
    // RL16 Supervisor only ops
    else if (privop && !r_q.priv)
    begin
      ex_hit = 1'b1;
      tt     = TT_PRIV;
    end
    // RL7 Float disabled trap
    else if (i_req.valid && i_req.op == WST_OP_FLOAT
             && (!r_q.float_en || !i_float_present))
    begin
      ex_hit = 1'b1;
      tt     = TT_FP_DIS;
    end
    // RL12 Invalid window check
    else if (i_req.valid && i_req.op == WST_OP_PUSH && r_q.window_invalid_mask[w_dec])
    begin
      ex_hit = 1'b1;
      tt     = TT_WOVF;
    end
    else if (i_req.valid && (i_req.op == WST_OP_POP
             || i_req.op == WST_OP_RET) && r_q.window_invalid_mask[w_inc])
    begin
      ex_hit = 1'b1;
      tt     = TT_WUNF;
    end
    else if (i_req.valid && i_req.exc[EX_ALIGN])
    begin
      ex_hit = 1'b1;
      tt     = TT_ALIGN;
    end
    else if (i_req.valid && i_req.exc[EX_FP_EXC])
    begin
      ex_hit = 1'b1;
      tt     = TT_FP_EXC;
    end
    else if (i_req.valid && i_req.exc[EX_DATA])
    begin
      ex_hit = 1'b1;
      tt     = TT_DACC;
    end
    else if (i_req.valid && i_req.exc[EX_TAG_OVF])
    begin
      ex_hit = 1'b1;
      tt     = TT_TAG_OVF;
    end
    else if (i_req.valid && i_req.op == WST_OP_TRAP)
    begin
      ex_hit = 1'b1;
      tt     = TT_SW_BASE | {1'b0, i_req.sw_trap};
    end
    // RL18 Irqs rank lowest
    else if (irq_take)
    begin
      take = 1'b1;
      tt   = irq_ttype;
    end
    sync_ex = ex_hit;

    unique case (r_q.state)
      WST_ST_RESET:
      begin
        // RL17 Reset trap first
        r_d.state      = WST_ST_RUN;
        r_d.priv       = 1'b1;
        r_d.prior_priv = 1'b0;
        r_d.trap_en    = 1'b0;
        r_d.ttype      = TT_RESET;
        r_d.trap.taken = 1'b1;
        r_d.trap.ttype = TT_RESET;
        r_d.trap.vector = 32'h00000000;
      end
      WST_ST_HALT:
        r_d.state = WST_ST_HALT;
      default:
      begin
        // RL10 Halt when traps off
        if (sync_ex && !r_q.trap_en)
          r_d.state = WST_ST_HALT;
        else if (sync_ex || take)
        begin
          // RL15 Trap replaces commit
          // RL22 Prior then supervisor
          r_d.prior_priv = r_q.priv;
          r_d.priv       = 1'b1;
          // RL10 Disable further traps
          r_d.trap_en    = 1'b0;
          // RL4 Trap decrements
          r_d.wptr       = {2'b00, w_dec};
          // RL13 Hardware type field
          r_d.ttype      = tt;
          r_d.trap.taken = 1'b1;
          r_d.trap.ttype = tt;
          // RL14 Base plus type offset
          r_d.trap.vector = {r_q.tbase, tt, 4'h0};
        end
        else if (i_req.valid)
        begin
          // RL6 Condition flag update
          if (i_req.cc_we)
            r_d.flags = i_req.cc_val;
          // RL20 Window and state updates
          unique case (i_req.op)
            // RL4 Push decrements
            WST_OP_PUSH:
              r_d.wptr = {2'b00, w_dec};
            // RL4 Pop increments
            WST_OP_POP:
              r_d.wptr = {2'b00, w_inc};
            WST_OP_RET:
            begin
              r_d.wptr    = {2'b00, w_inc};
              r_d.priv    = r_q.prior_priv;
              r_d.trap_en = 1'b1;
            end
            WST_OP_WR_PS:
            begin
              r_d.flags      = i_req.wdata[PS_FLAG_C +: 4];
              // RL11 Kept as written
              r_d.coproc_en  = i_req.wdata[PS_COPROC_EN];
              r_d.float_en   = i_req.wdata[PS_FLOAT_EN];
              r_d.mask       = i_req.wdata[PS_MASK_LSB +: 4];
              // RL9 Privilege fields
              r_d.priv       = i_req.wdata[PS_PRIV];
              r_d.prior_priv = i_req.wdata[PS_PRIOR_PRIV];
              r_d.trap_en    = i_req.wdata[PS_TRAP_EN];
              r_d.wptr       = {2'b00, i_req.wdata[2:0]};
            end
            WST_OP_RD_PS:
              r_d.rdata = ps_word;
            WST_OP_WR_WIM:
              r_d.window_invalid_mask = i_req.wdata[7:0];
            WST_OP_RD_WIM:
              r_d.rdata = {24'h000000, r_q.window_invalid_mask};
            WST_OP_WR_TB:
              r_d.tbase = i_req.wdata[TB_BASE_LSB +: 20];
            // RL13 Low nibble reads zero
            WST_OP_RD_TB:
              r_d.rdata = {r_q.tbase, r_q.ttype, 4'h0};
            // RL19 Partial product hold
            WST_OP_WR_PP:
              r_d.pprod = i_req.wdata;
            WST_OP_RD_PP:
              r_d.rdata = r_q.pprod;
            default:
              r_d.rdata = 32'h00000000;
          endcase
        end
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_q.state      <= WST_ST_RESET;
      r_q.flags      <= 4'h0;
      r_q.coproc_en  <= 1'b0;
      r_q.float_en   <= 1'b0;
      r_q.mask       <= MASK_RST;
      r_q.priv       <= 1'b1;
      r_q.prior_priv <= 1'b0;
      r_q.trap_en    <= 1'b0;
      r_q.wptr       <= WPTR_RST;
      r_q.window_invalid_mask        <= WIM_RST;
      r_q.tbase      <= TBASE_RST;
      r_q.ttype      <= TT_RESET;
      r_q.pprod      <= PPROD_RST;
      r_q.trap       <= '0;
      r_q.rdata      <= 32'h00000000;
    end
    else
    begin
      r_q.state      <= r_d.state;
      r_q.flags      <= r_d.flags;
      r_q.coproc_en  <= r_d.coproc_en;
      r_q.float_en   <= r_d.float_en;
      r_q.mask       <= r_d.mask;
      r_q.priv       <= r_d.priv;
      r_q.prior_priv <= r_d.prior_priv;
      r_q.trap_en    <= r_d.trap_en;
      r_q.wptr       <= r_d.wptr;
      r_q.window_invalid_mask        <= r_d.window_invalid_mask;
      r_q.tbase      <= r_d.tbase;
      r_q.ttype      <= r_d.ttype;
      r_q.pprod      <= r_d.pprod;
      r_q.trap       <= r_d.trap;
      r_q.rdata      <= r_d.rdata;
    end
  end

  // ==========================================================
  // Outputs
  assign o_trap       = r_q.trap;
  assign o_rdata      = r_q.rdata;
  assign o_halted     = r_q.state[2];
  assign o_supervisor = r_q.priv;
  assign o_rf_a       = rf_a;
  assign o_rf_b       = rf_b;

endmodule : wst_core

// *** hdl/wst_irq_pick.sv ***
// Interrupt level filter against the level mask
`timescale 1ns/1ps
module wst_irq_pick
  import wst_pkg::*;
(
  input  wire logic [3:0] i_level,
  input  wire logic [3:0] i_mask,
  input  wire logic       i_trap_en,
  output logic            o_take,
  output logic [7:0]      o_ttype
);

  // RL8 Strictly above mask
  always_comb
  begin
    o_take  = i_trap_en && (i_level > i_mask) && (i_level != 4'h0);
    // RL18 Level to type
    o_ttype = TT_IRQ_BASE | {4'h0, i_level};
  end

endmodule : wst_irq_pick

// *** hdl/wst_regfile.sv ***
// Windowed working register file storage
`timescale 1ns/1ps
module wst_regfile
  import wst_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic [2:0]        i_win,
  input  wire wst_pkg::wst_rf_req_t i_req,
  output logic [31:0]            o_rdata_a,
  output logic [31:0]            o_rdata_b
);

  logic [31:0] mem_q [NUM_REGS];

  // ==========================================================
  // Register address to physical slot
  function automatic logic [7:0] phys(input logic [2:0] win,
                                      input logic [4:0] r);
    logic [2:0] w;
    w = win;
    if (r[4:3] == 2'd0)
      phys = {5'h00, r[2:0]};
    // RL3 Outs overlap next
    else if (r[4:3] == 2'd1)
      phys = 8'(NUM_GLOBAL) + {w - 3'd1, 4'h0} + {5'h00, r[2:0]};
    else if (r[4:3] == 2'd2)
      phys = 8'(NUM_GLOBAL) + {w, 4'h8} + {5'h00, r[2:0]};
    else
      phys = 8'(NUM_GLOBAL) + {w, 4'h0} + {5'h00, r[2:0]};
  endfunction : phys

  // RL1 Global zero read
  always_comb
  begin
    o_rdata_a = (i_req.raddr_a == 5'h00) ? 32'h00000000
              : mem_q[phys(i_win, i_req.raddr_a)];
    o_rdata_b = (i_req.raddr_b == 5'h00) ? 32'h00000000
              : mem_q[phys(i_win, i_req.raddr_b)];
  end

  // RL2 Window write port
  always_ff @(posedge i_core_clk)
  begin
    if (i_req.we && i_req.waddr != 5'h00)
      mem_q[phys(i_win, i_req.waddr)] <= i_req.wdata;
  end

endmodule : wst_regfile

// *** testbench/window_state_trap_control_test.sv ***
// Self-checking bench for the window, state and trap unit
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module window_state_trap_control_test;
  import wst_pkg::*;
  logic        i_core_clk;
  logic        i_rstn;
  logic        fp_on;
  logic [15:1] pend;
  logic [3:0]  irq_level;
  wst_req_t    req;
  wst_rf_req_t rf;
  wst_trap_t   trap;
  wst_trap_t   tc;
  logic [31:0] rdata;
  logic [31:0] rc;
  logic [31:0] rf_a;
  logic [31:0] rf_b;
  logic        halted;
  logic        sup;
  int          mismatches;
  int          checks;
  wst_op_t     ops [8];
  logic [5:0]  exs [8];
  logic [7:0]  tts [8];

  wst_core dut_u (
    .i_core_clk (i_core_clk), .i_rstn (i_rstn), .i_req (req),
    .i_float_present (fp_on), .i_irq_level (irq_level), .i_rf_req (rf),
    .o_trap (trap), .o_rdata (rdata), .o_halted (halted),
    .o_supervisor (sup), .o_rf_a (rf_a), .o_rf_b (rf_b)
  );
  wst_irq_src irq_u (
    .i_core_clk (i_core_clk), .i_pending (pend), .o_level (irq_level)
  );

  initial
  begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end

  // ==========================================================
  // Access tasks
  function automatic logic [31:0] psw(logic [3:0] f, logic ef,
    logic [3:0] m, logic s, logic p, logic et, logic [4:0] w);
    return {DESIGN_ID_VAL, VERSION_VAL, f, 6'h00, 1'b0, ef, m, s, p, et, w};
  endfunction : psw

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic wait_trap(int lim);
    int n;
    n = 0;
    while (trap.taken !== 1'b1 && n < lim)
    begin
      @(posedge i_core_clk);
      #1;
      n++;
    end
    if (trap.taken !== 1'b1)
    begin
      mismatches++;
      give_verdict();
    end
  endtask : wait_trap

  task automatic do_op(wst_op_t op, logic [31:0] wd,
    logic [5:0] ex = 6'h00, logic ccw = 1'b0);
    @(posedge i_core_clk);
    req <= '{1'b1, op, wd, 7'h05, ccw, 4'ha, ex};
    @(posedge i_core_clk);
    req.valid <= 1'b0;
    #1;
    tc = trap;
    rc = rdata;
  endtask : do_op

  task automatic rd(wst_op_t op, logic [31:0] e);
    do_op(op, 32'h0);
    `CHK(rc, e)
  endtask : rd

  task automatic tchk(wst_op_t op, logic [5:0] ex, logic [7:0] tt);
    do_op(op, 32'h0, ex, 1'b1);
    `CHK(tc.taken, 1'b1)
    `CHK(tc.ttype, tt)
    `CHK(tc.vector, {20'h12345, tt, 4'h0})
  endtask : tchk

  task automatic sps(logic ef, logic [3:0] m, logic s, logic et,
    logic [4:0] w);
    do_op(WST_OP_WR_PS, psw(4'h5, ef, m, s, 1'b0, et, w));
  endtask : sps

  task automatic rf_wr(logic [4:0] a, logic [31:0] d);
    @(posedge i_core_clk);
    rf <= '{1'b1, a, d, 5'd0, 5'd0};
    @(posedge i_core_clk);
    rf.we <= 1'b0;
  endtask : rf_wr

  task automatic rf_rd(logic [4:0] a, logic [4:0] b, logic [31:0] ea,
    logic [31:0] eb);
    @(posedge i_core_clk);
    rf <= '{1'b0, 5'd0, 32'h0, a, b};
    #1;
    `CHK(rf_a, ea)
    `CHK(rf_b, eb)
  endtask : rf_rd

  task automatic do_reset;
    @(posedge i_core_clk);
    i_rstn <= 1'b0;
    repeat (10) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    wait_trap(8);
    `CHK(trap.ttype, TT_RESET)
    `CHK(trap.vector, 32'h0)
    `CHK(sup, 1'b1)
    `CHK(halted, 1'b0)
  endtask : do_reset

  // ==========================================================
  // Main sequence
  initial
  begin
    i_rstn = 1'b0;
    fp_on = 1'b0;
    pend = '0;
    req = '0;
    rf = '0;
    mismatches = 0;
    checks = 0;
    ops = '{WST_OP_NONE, WST_OP_NONE, WST_OP_PUSH, WST_OP_NONE,
            WST_OP_NONE, WST_OP_NONE, WST_OP_NONE, WST_OP_TRAP};
    exs = '{6'h3f, 6'h3e, 6'h38, 6'h38, 6'h34, 6'h24, 6'h20, 6'h00};
    tts = '{8'h01, 8'h02, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h85};
    do_reset();
    sps(1'b1, 4'h3, 1'b1, 1'b1, 5'd2);
    rd(WST_OP_RD_PS, psw(4'h5, 1'b1, 4'h3, 1'b1, 1'b0, 1'b1, 5'd2));
    do_op(WST_OP_WR_TB, 32'h12345000);
    rd(WST_OP_RD_TB, 32'h12345000);
    do_op(WST_OP_NONE, 32'h0, 6'h00, 1'b1);
    rd(WST_OP_RD_PS, psw(4'ha, 1'b1, 4'h3, 1'b1, 1'b0, 1'b1, 5'd2));
    do_op(WST_OP_WR_PP, 32'hdeadbeef);
    rd(WST_OP_RD_PP, 32'hdeadbeef);
    do_op(WST_OP_WR_WIM, 32'h2);
    rd(WST_OP_RD_WIM, 32'h2);
    rf_wr(5'd9, 32'hcafe0009);
    rf_wr(5'd3, 32'h00000333);
    tchk(WST_OP_PUSH, 6'h00, TT_WOVF);
    rd(WST_OP_RD_PS, psw(4'ha, 1'b1, 4'h3, 1'b1, 1'b1, 1'b0, 5'd1));
    rd(WST_OP_RD_TB, 32'h12345050);
    do_op(WST_OP_WR_WIM, 32'h4);
    sps(1'b1, 4'h3, 1'b1, 1'b1, 5'd2);
    do_op(WST_OP_PUSH, 32'h0);
    rf_rd(5'd25, 5'd3, 32'hcafe0009, 32'h333);
    rf_rd(5'd0, 5'd3, 32'h0, 32'h333);
    tchk(WST_OP_POP, 6'h00, TT_WUNF);
    sps(1'b1, 4'h3, 1'b1, 1'b1, 5'd0);
    do_op(WST_OP_PUSH, 32'h0);
    rd(WST_OP_RD_PS, psw(4'h5, 1'b1, 4'h3, 1'b1, 1'b0, 1'b1, 5'd7));
    sps(1'b1, 4'h3, 1'b1, 1'b0, 5'd7);
    do_op(WST_OP_RET, 32'h0);
    `CHK(sup, 1'b0)
    tchk(WST_OP_RD_PS, 6'h00, TT_PRIV);
    `CHK(sup, 1'b1)
    rd(WST_OP_RD_PS, psw(4'h5, 1'b1, 4'h3, 1'b1, 1'b0, 1'b0, 5'd7));
    @(posedge i_core_clk) fp_on <= 1'b1;
    sps(1'b0, 4'h3, 1'b1, 1'b1, 5'd2);
    tchk(WST_OP_FLOAT, 6'h00, TT_FP_DIS);
    @(posedge i_core_clk) fp_on <= 1'b0;
    sps(1'b1, 4'h3, 1'b1, 1'b1, 5'd2);
    tchk(WST_OP_FLOAT, 6'h00, TT_FP_DIS);
    @(posedge i_core_clk) fp_on <= 1'b1;
    sps(1'b1, 4'h3, 1'b1, 1'b1, 5'd2);
    do_op(WST_OP_FLOAT, 32'h0);
    `CHK(tc.taken, 1'b0)
    do_op(WST_OP_WR_WIM, 32'h2);
    for (int i = 0; i < 8; i++)
    begin
      sps(1'b1, 4'hf, 1'b1, 1'b1, 5'd2);
      tchk(ops[i], exs[i], tts[i]);
    end
    sps(1'b1, 4'h3, 1'b1, 1'b1, 5'd2);
    @(posedge i_core_clk) pend <= 15'h0004;
    repeat (4) @(posedge i_core_clk);
    rd(WST_OP_RD_PS, psw(4'h5, 1'b1, 4'h3, 1'b1, 1'b0, 1'b1, 5'd2));
    @(posedge i_core_clk) pend <= 15'h000c;
    wait_trap(6);
    `CHK(trap.ttype, 8'h14)
    @(posedge i_core_clk) pend <= 15'h400c;
    repeat (4) @(posedge i_core_clk);
    rd(WST_OP_RD_PS, psw(4'h5, 1'b1, 4'h3, 1'b1, 1'b1, 1'b0, 5'd1));
    sps(1'b1, 4'h3, 1'b1, 1'b1, 5'd1);
    wait_trap(6);
    `CHK(trap.ttype, 8'h1f)
    @(posedge i_core_clk) pend <= '0;
    do_op(WST_OP_NONE, 32'h0, 6'h04);
    `CHK(tc.taken, 1'b0)
    `CHK(halted, 1'b1)
    do_reset();
    give_verdict();
  end
endmodule : window_state_trap_control_test

// *** testbench/wst_core_sva.sv ***
// Assertion checker for the window, state and trap unit
`timescale 1ns/1ps
module wst_core_chk
  import wst_pkg::*;
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rstn,
  input  wire wst_pkg::wst_req_t     i_req,
  input  wire logic                  i_float_present,
  input  wire logic [3:0]            i_irq_level,
  input  wire wst_pkg::wst_rf_req_t  i_rf_req,
  input  wire wst_pkg::wst_trap_t    o_trap,
  input  wire logic [31:0]           o_rdata,
  input  wire logic                  o_halted,
  input  wire logic                  o_supervisor,
  input  wire logic [31:0]           o_rf_a,
  input  wire logic [31:0]           o_rf_b
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  a_halt_sticks: assert property (o_halted |=> o_halted)
    else $error("halt state dropped");
  a_halt_quiet: assert property (o_halted |-> !o_trap.taken)
    else $error("trap pulse while halted");
  a_trap_single: assert property (o_trap.taken |=> !o_trap.taken)
    else $error("trap pulse longer than one cycle");
  a_trap_super: assert property (o_trap.taken |-> o_supervisor)
    else $error("trap entry left user mode");
  a_vector_low: assert property (o_trap.taken |->
    o_trap.vector[11:0] == {o_trap.ttype, 4'h0})
    else $error("vector offset not taken from trap type");
  a_irq_map: assert property (o_trap.taken &&
    o_trap.ttype[7:4] == 4'h1 |-> o_trap.ttype[3:0] == $past(i_irq_level))
    else $error("interrupt type does not match level");
  a_iacc_first: assert property (i_req.valid && i_req.exc[EX_IACC]
    |=> o_halted || (o_trap.taken && o_trap.ttype == TT_IACC))
    else $error("instruction access not ranked first");
  a_fp_off: assert property (i_req.valid &&
    i_req.op == WST_OP_FLOAT && !i_float_present && i_req.exc == '0
    |=> o_halted || (o_trap.taken && o_trap.ttype == TT_FP_DIS))
    else $error("float op without unit did not trap");
  a_user_priv: assert property (i_req.valid && !o_supervisor &&
    i_req.op == WST_OP_RD_PS && i_req.exc == '0
    |=> o_halted || (o_trap.taken && o_trap.ttype == TT_PRIV))
    else $error("privileged op ran in user mode");
  a_rdata_idle: assert property (!i_req.valid |=> o_rdata == 32'h0)
    else $error("read data without a read");
  a_zero_reg: assert property (i_rf_req.raddr_a == 5'h00 |->
    o_rf_a == 32'h0)
    else $error("register zero not zero");

  c_reset_trap: cover property (o_trap.taken && o_trap.ttype == TT_RESET);
  c_irq_trap: cover property (o_trap.taken && o_trap.ttype[7:4] == 4'h1);
  c_halt: cover property ($rose(o_halted));
endmodule : wst_core_chk

bind wst_core wst_core_chk chk_u (
  .i_core_clk (i_core_clk), .i_rstn (i_rstn), .i_req (i_req),
  .i_float_present (i_float_present), .i_irq_level (i_irq_level),
  .i_rf_req (i_rf_req), .o_trap (o_trap), .o_rdata (o_rdata),
  .o_halted (o_halted), .o_supervisor (o_supervisor),
  .o_rf_a (o_rf_a), .o_rf_b (o_rf_b)
);

// *** testbench/wst_irq_src.sv ***
// Interrupt prioritiser model presenting the highest pending level
`timescale 1ns/1ps
module wst_irq_src
  import wst_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic [15:1] i_pending,
  output logic [3:0]       o_level = 4'h0
);
  // ==========================================================
  // Level encoder
  // higher level wins
  always @(posedge i_core_clk)
  begin
    o_level <= 4'h0;
    for (int l = 1; l < 16; l++)
    begin
      if (i_pending[l])
      begin
        o_level <= l[3:0];
      end
    end
  end
endmodule : wst_irq_src
